// ===== pkg/csg_pkg.sv
package csg_pkg;
   // strap levels when nothing drives the pin
   localparam logic STRAP_PULL_LVL = 1'b1;
   localparam int MEM_CLK_COUNT = 12;
   localparam int CPU_TRUE_COUNT = 2;
   localparam int FREQ_SEL_W = 4;
   localparam int SYNC_STAGES = 3;
   // freq step: one code per step period
   localparam int STEP_TIME_US = 10;
   localparam int CLK_MHZ = 20;
   localparam int STEP_CYCLES = STEP_TIME_US * CLK_MHZ;
   // identity values are arbitrary
   localparam logic [7:0] VENDOR_ID_DEF = 8'h5a;
   localparam logic [7:0] DEVICE_ID_DEF = 8'h3c;
   localparam logic [7:0] REV_ID_DEF = 8'h01;

   typedef struct packed {
      logic mode;
      logic aux_rate;
      logic [FREQ_SEL_W-1:0] freq;
   } csg_straps_t;

   typedef struct packed {
      logic [7:0] vendor;
      logic [7:0] device;
      logic [7:0] rev;
   } csg_ident_t;

   typedef enum logic [1:0] {
      CSG_SAMPLE = 2'b00,
      CSG_WAIT = 2'b01,
      CSG_RUN = 2'b11
   } csg_state_t;
endpackage

// ===== hdl/csg_clock_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - mode strap picks halt input or refclk
// - mode pin becomes bus clock after latch
// - halt low stops cpu and mem 0-11
// - free mem clock runs during halt
// - free mem clock stops on power-down
// - power-down stops all outputs, pulled up
// - freq straps sampled, pins set to drive after latch (no clock on them)
// - freq straps 0,1,3 default high
// - aux strap high 24MHz low 48MHz
// - aux strap pin becomes bus clock
// - second refclk only after strap latch
// - mem buffer input fans to thirteen outputs
// - freq change steps linearly, glitch free
// - power-down also enterable by host
// - identity values readable by host
module csg_clock_ctrl #(
   parameter int STEP_CYC = csg_pkg::STEP_CYCLES
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_ref_clk,
   input wire logic i_bus_clk,
   input wire logic i_cpu_clk,
   input wire logic i_aux_clk_24,
   input wire logic i_aux_clk_48,
   input wire logic i_mem_clk_buffer_in,
   input wire logic i_mode_strap,
   input wire logic i_aux_rate_strap,
   input wire logic i_freq_strap_0,
   input wire logic i_freq_strap_1,
   input wire logic i_freq_strap_2,
   input wire logic i_freq_strap_3,
   input wire logic i_freq_strap_0_oe_n,
   input wire logic i_freq_strap_1_oe_n,
   input wire logic i_freq_strap_3_oe_n,
   input wire logic i_halt_pin,
   input wire logic i_power_down_n,
   input wire logic i_power_down_n_oe_n,
   input wire logic i_host_power_down,
   input wire logic i_host_freq_wr,
   input wire logic [csg_pkg::FREQ_SEL_W-1:0] i_host_freq,
   output logic o_latched,
   output csg_pkg::csg_straps_t o_straps,
   output csg_pkg::csg_ident_t o_ident,
   output logic [csg_pkg::FREQ_SEL_W-1:0] o_freq_sel,
   output logic o_pin2_oe_n,
   output logic o_pin2,
   output logic o_mode_pin,
   output logic o_mode_pin_oe_n,
   output logic o_aux_strap_pin,
   output logic o_aux_strap_pin_oe_n,
   output logic o_freq_pins_oe_n,
   output logic o_ref_clk_out_b,
   output logic o_aux_clk_out,
   output logic [csg_pkg::CPU_TRUE_COUNT-1:0] o_cpu_clk_true_out,
   output logic o_cpu_clk_comp_out,
   output logic [csg_pkg::MEM_CLK_COUNT-1:0] o_mem_clk_out,
   output logic o_mem_clk_free_out
);
   import csg_pkg::*;

   csg_state_t state_r, state_nxt;
   csg_straps_t straps_r;
   logic [SYNC_STAGES-1:0] halt_sync_r, pd_sync_r;
   logic halt_n_r, pd_n_r;
   logic [FREQ_SEL_W-1:0] freq_r, freq_tgt_r;
   logic [$clog2(STEP_CYC+1)-1:0] step_cnt_r;
   logic fs0_lvl, fs1_lvl, fs3_lvl, pd_pin_lvl;
   logic pd_all, halt_act, step_tick;

   // undriven pins read through the pull-up level
   assign fs0_lvl = i_freq_strap_0_oe_n ? STRAP_PULL_LVL : i_freq_strap_0;
   assign fs1_lvl = i_freq_strap_1_oe_n ? STRAP_PULL_LVL : i_freq_strap_1;
   assign fs3_lvl = i_freq_strap_3_oe_n ? STRAP_PULL_LVL : i_freq_strap_3;
   assign pd_pin_lvl = i_power_down_n_oe_n ? STRAP_PULL_LVL : i_power_down_n;

   // latch sequence: sample one cycle after release, then hand pins back
   always_comb begin
      case (state_r)
         CSG_SAMPLE: state_nxt = CSG_WAIT;
         CSG_WAIT: state_nxt = CSG_RUN;
         CSG_RUN: state_nxt = CSG_RUN;
         default: state_nxt = CSG_RUN;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_r <= CSG_SAMPLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // straps caught once by a clocked process after release; never again
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         straps_r <= '1;
      end else if (state_r == CSG_SAMPLE) begin
         straps_r.mode <= i_mode_strap;
         straps_r.aux_rate <= i_aux_rate_strap;
         straps_r.freq <= {fs3_lvl, i_freq_strap_2, fs1_lvl, fs0_lvl};
      end
   end

   // three-stage sync; second and third must agree before a change counts
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         halt_sync_r <= '1;
         pd_sync_r <= '1;
         halt_n_r <= 1'b1;
         pd_n_r <= 1'b1;
      end else begin
         halt_sync_r <= {halt_sync_r[SYNC_STAGES-2:0], i_halt_pin};
         pd_sync_r <= {pd_sync_r[SYNC_STAGES-2:0], pd_pin_lvl};
         if (halt_sync_r[1] == halt_sync_r[2]) begin
            halt_n_r <= halt_sync_r[2];
         end
         if (pd_sync_r[1] == pd_sync_r[2]) begin
            pd_n_r <= pd_sync_r[2];
         end
      end
   end

   assign o_latched = (state_r == CSG_RUN);
   // halt input only exists when the mode strap chose input
   assign halt_act = o_latched && !straps_r.mode && !halt_n_r;
   assign pd_all = !pd_n_r || i_host_power_down;

   // step timer; one code per tick so the pll walks in small steps
   assign step_tick = (step_cnt_r == ($bits(step_cnt_r))'(STEP_CYC - 1));
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         step_cnt_r <= '0;
      end else begin
         step_cnt_r <= step_tick ? '0 : step_cnt_r + 1'b1;
      end
   end

   // frequency code: loads from straps, then walks toward host target
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         freq_r <= '1;
         freq_tgt_r <= '1;
      end else if (state_r == CSG_WAIT) begin
         freq_r <= straps_r.freq;
         freq_tgt_r <= straps_r.freq;
      end else if (o_latched) begin
         if (i_host_freq_wr) begin
            freq_tgt_r <= i_host_freq;
         end
         if (step_tick && freq_r < freq_tgt_r) begin
            freq_r <= freq_r + 1'b1;
         end else if (step_tick && freq_r > freq_tgt_r) begin
            freq_r <= freq_r - 1'b1;
         end
      end
   end

   assign o_freq_sel = freq_r;
   assign o_straps = straps_r;
   assign o_ident = '{vendor: VENDOR_ID_DEF, device: DEVICE_ID_DEF, rev: REV_ID_DEF};

   // pin directions: inputs until latch, outputs after, except pin2 stays input when mode strap is low (oe low = driving)
   assign o_pin2_oe_n = !(o_latched && straps_r.mode);
   assign o_pin2 = o_latched && straps_r.mode && !pd_all && i_ref_clk;
   assign o_mode_pin_oe_n = !o_latched;
   assign o_mode_pin = o_latched && !pd_all && i_bus_clk;
   assign o_aux_strap_pin_oe_n = !o_latched;
   assign o_aux_strap_pin = o_latched && !pd_all && i_bus_clk;
   assign o_freq_pins_oe_n = !o_latched;
   assign o_ref_clk_out_b = o_latched && !pd_all && i_ref_clk;
   assign o_aux_clk_out = o_latched && !pd_all &&
                          (straps_r.aux_rate ? i_aux_clk_24 : i_aux_clk_48);

   // gating is combinational: clocks pass the and gate, no flop delay
   assign o_cpu_clk_true_out = {CPU_TRUE_COUNT{!pd_all && !halt_act && i_cpu_clk}};
   assign o_cpu_clk_comp_out = !pd_all && !halt_act && !i_cpu_clk;
   assign o_mem_clk_out = {MEM_CLK_COUNT{!pd_all && !halt_act && i_mem_clk_buffer_in}};
   assign o_mem_clk_free_out = !pd_all && i_mem_clk_buffer_in;

   property p_strap_hold;
      @(posedge i_clk) disable iff (!i_rst_n)
      o_latched |=> $stable(straps_r);
   endproperty
   a_strap_hold: assert property (p_strap_hold) else $error("straps changed after latch");

   property p_latch_time;
      @(posedge i_clk) disable iff (!i_rst_n)
      (state_r == CSG_SAMPLE) |-> ##2 o_latched;
   endproperty
   a_latch_time: assert property (p_latch_time) else $error("latch not done in two cycles");

   property p_halt_cpu;
      @(posedge i_clk) disable iff (!i_rst_n)
      halt_act |-> (o_cpu_clk_true_out == '0) && !o_cpu_clk_comp_out && (o_mem_clk_out == '0);
   endproperty
   a_halt_cpu: assert property (p_halt_cpu) else $error("clock ran during halt");

   property p_free_runs;
      @(posedge i_clk) disable iff (!i_rst_n)
      (halt_act && !pd_all) |-> (o_mem_clk_free_out == i_mem_clk_buffer_in);
   endproperty
   a_free_runs: assert property (p_free_runs) else $error("free clock stopped by halt");

   property p_pd_stop;
      @(posedge i_clk) disable iff (!i_rst_n)
      pd_all |-> !o_mem_clk_free_out && !o_aux_clk_out && !o_ref_clk_out_b && !o_mode_pin;
   endproperty
   a_pd_stop: assert property (p_pd_stop) else $error("clock ran in power-down");

   property p_pd_pin;
      @(posedge i_clk) disable iff (!i_rst_n)
      (!pd_sync_r[2] && !pd_sync_r[1]) |=> (o_cpu_clk_true_out == '0);
   endproperty
   a_pd_pin: assert property (p_pd_pin) else $error("pin power-down ignored");

   property p_host_pd;
      @(posedge i_clk) disable iff (!i_rst_n)
      i_host_power_down |-> !o_cpu_clk_comp_out && (o_mem_clk_out == '0);
   endproperty
   a_host_pd: assert property (p_host_pd) else $error("host power-down ignored");

   property p_step;
      @(posedge i_clk) disable iff (!i_rst_n)
      (o_latched && $past(o_latched)) |-> (freq_r - $past(freq_r) == 4'h1) ||
         ($past(freq_r) - freq_r == 4'h1) || (freq_r == $past(freq_r));
   endproperty
   a_step: assert property (p_step) else $error("frequency jumped more than one step");

   property p_pin_dir;
      @(posedge i_clk) disable iff (!i_rst_n)
      !o_latched |-> o_mode_pin_oe_n && o_aux_strap_pin_oe_n && o_freq_pins_oe_n && o_pin2_oe_n;
   endproperty
   a_pin_dir: assert property (p_pin_dir) else $error("strap pin driven before latch");
endmodule
`default_nettype wire

// ===== testbench/csg_far_side.sv
`timescale 1ns/1ps
`default_nettype none
// board straps and chipset side of the shared pins
module csg_far_side (
   input wire logic i_latched,
   input wire logic i_float,
   input wire csg_pkg::csg_straps_t i_level,
   output logic o_mode,
   output logic o_aux,
   output logic [csg_pkg::FREQ_SEL_W-1:0] o_freq,
   output logic o_float_oe_n
);
   import csg_pkg::*;
   // levels until latch; released after, so show the inverse to expose a late sample
   assign o_mode = i_latched ? ~i_level.mode : i_level.mode;
   assign o_aux = i_latched ? ~i_level.aux_rate : i_level.aux_rate;
   // floating pins carry 0, only the pull-up can make them read high
   assign o_freq = (i_latched ? ~i_level.freq : i_level.freq) & (i_float ? 4'h4 : 4'hf);
   assign o_float_oe_n = i_float;
endmodule
`default_nettype wire

// ===== testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import csg_pkg::*;
   localparam int STEP = 4;
   logic i_clk, i_rst_n = 1'b0, src = 1'b1, buf_in = 1'b1, halt_n = 1'b1, pd_n = 1'b1;
   logic pd_oe_n = 1'b0, host_pd = 1'b0, wr = 1'b0, flt = 1'b1, f_mode, f_aux, f_oe_n;
   logic [FREQ_SEL_W-1:0] host_freq = 4'h0, f_freq, fsel;
   csg_straps_t lvl = 6'h00, straps;
   csg_ident_t ident;
   logic latched, pin2_oe_n, pin2, mode_pin, mode_oe_n, aux_pin, aux_oe_n, fp_oe_n, ref_b, aux_out, comp, free;
   logic [CPU_TRUE_COUNT-1:0] cpu_t;
   logic [MEM_CLK_COUNT-1:0] mem;
   int error_cnt = 0, compares = 0;
   initial begin
      i_clk = 1'b0;
      forever #25 i_clk = ~i_clk;
   end
   csg_far_side csg_far_side_inst (.i_latched(latched), .i_float(flt), .i_level(lvl), .o_mode(f_mode),
      .o_aux(f_aux), .o_freq(f_freq), .o_float_oe_n(f_oe_n));
   // shared pins: device drive wins once its enable is low
   csg_clock_ctrl #(.STEP_CYC(STEP)) csg_clock_ctrl_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ref_clk(src),
      .i_bus_clk(src), .i_cpu_clk(src), .i_aux_clk_24(src), .i_aux_clk_48(~src), .i_mem_clk_buffer_in(buf_in),
      .i_mode_strap(mode_oe_n ? f_mode : mode_pin), .i_aux_rate_strap(aux_oe_n ? f_aux : aux_pin),
      .i_freq_strap_0(f_freq[0]), .i_freq_strap_1(f_freq[1]), .i_freq_strap_2(f_freq[2]),
      .i_freq_strap_3(f_freq[3]), .i_freq_strap_0_oe_n(f_oe_n), .i_freq_strap_1_oe_n(f_oe_n),
      .i_freq_strap_3_oe_n(f_oe_n), .i_halt_pin(halt_n), .i_power_down_n(pd_n), .i_power_down_n_oe_n(pd_oe_n),
      .i_host_power_down(host_pd), .i_host_freq_wr(wr), .i_host_freq(host_freq), .o_latched(latched),
      .o_straps(straps), .o_ident(ident), .o_freq_sel(fsel), .o_pin2_oe_n(pin2_oe_n), .o_pin2(pin2),
      .o_mode_pin(mode_pin), .o_mode_pin_oe_n(mode_oe_n), .o_aux_strap_pin(aux_pin),
      .o_aux_strap_pin_oe_n(aux_oe_n), .o_freq_pins_oe_n(fp_oe_n), .o_ref_clk_out_b(ref_b),
      .o_aux_clk_out(aux_out), .o_cpu_clk_true_out(cpu_t), .o_cpu_clk_comp_out(comp),
      .o_mem_clk_out(mem), .o_mem_clk_free_out(free));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      if (error_cnt == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // reset, then latch on the second edge after release (state reaches run there)
   task automatic do_reset(input csg_straps_t v);
      lvl = v;
      i_rst_n = 1'b0;
      repeat (2) @(negedge i_clk);
      check(ref_b, 1'b0);
      i_rst_n = 1'b1;
      @(negedge i_clk);
      check(latched, 1'b0);
      @(negedge i_clk);
      check(latched, 1'b1);
      v.freq = flt ? (v.freq | 4'hb) : v.freq;
      check(straps, v);
      check(fsel, v.freq);
      check({pin2_oe_n, mode_oe_n, aux_oe_n, fp_oe_n}, {~v.mode, 3'b000});
      repeat (3) @(negedge i_clk);
      check(straps, v);
   endtask
   // both source levels, so a stuck output cannot pass
   task automatic chk_gate(input logic run, input logic free_run);
      for (int v = 0; v < 2; v++) begin
         src = v[0];
         buf_in = v[0];
         #1;
         check(cpu_t, {CPU_TRUE_COUNT{v[0] & run}});
         check(comp, ~v[0] & run);
         check(mem, {MEM_CLK_COUNT{v[0] & run}});
         check(free, v[0] & free_run);
      end
   endtask
   // either direction: one code per step period, no skipped code
   task automatic step_to(input logic [FREQ_SEL_W-1:0] tgt);
      logic [FREQ_SEL_W-1:0] prev;
      int cyc;
      logic first;
      prev = fsel;
      cyc = 0;
      first = 1'b1;
      host_freq = tgt;
      wr = 1'b1;
      @(negedge i_clk);
      wr = 1'b0;
      for (int n = 0; n < 100 && fsel !== tgt; n++) begin
         @(negedge i_clk);
         cyc++;
         if (fsel !== prev) begin
            check(fsel, (tgt > prev) ? prev + 4'h1 : prev - 4'h1);
            check(first || cyc == STEP, 1'b1);
            prev = fsel;
            cyc = 0;
            first = 1'b0;
         end
      end
      if (fsel !== tgt) begin
         error_cnt++;
         $display("FAIL %0t frequency target not reached", $time);
         finish_test();
      end
   endtask
   initial begin
      do_reset(csg_straps_t'{1'b0, 1'b1, 4'h2});
      check(aux_out, src);
      check(ref_b, src);
      check({mode_pin, aux_pin}, {src, src});
      check(ident, {VENDOR_ID_DEF, DEVICE_ID_DEF, REV_ID_DEF});
      chk_gate(1'b1, 1'b1);
      halt_n = 1'b0;
      repeat (5) @(negedge i_clk);
      chk_gate(1'b0, 1'b1);
      halt_n = 1'b1;
      pd_n = 1'b0;
      repeat (5) @(negedge i_clk);
      chk_gate(1'b0, 1'b0);
      check({aux_out, ref_b, mode_pin, aux_pin}, 4'h0);
      pd_oe_n = 1'b1;
      repeat (5) @(negedge i_clk);
      chk_gate(1'b1, 1'b1);
      pd_oe_n = 1'b0;
      pd_n = 1'b1;
      host_pd = 1'b1;
      repeat (2) @(negedge i_clk);
      chk_gate(1'b0, 1'b0);
      host_pd = 1'b0;
      step_to(4'h8);
      step_to(4'ha);
      flt = 1'b0;
      do_reset(csg_straps_t'{1'b1, 1'b0, 4'h5});
      check({pin2, aux_out}, {src, ~src});
      halt_n = 1'b0;
      repeat (5) @(negedge i_clk);
      chk_gate(1'b1, 1'b1);
      finish_test();
   end
endmodule
`default_nettype wire
